/* File: lpmn_regs.svh */
// constants for the link power-management entry negotiation block
`ifndef LPMN_REGS_SVH
`define LPMN_REGS_SVH
// message codes, code[7:0]
`define LPMN_CODE_AS_NAK 8'h14
`define LPMN_CODE_PME 8'h18
`define LPMN_CODE_TURN_OFF 8'h19
`define LPMN_CODE_TO_ACK 8'h1B
// routing subfield r[2:0]
`define LPMN_ROUTE_AS_NAK 3'h4
`define LPMN_ROUTE_PME 3'h0
`define LPMN_ROUTE_TURN_OFF 3'h3
`define LPMN_ROUTE_TO_ACK 3'h5
// attribute and traffic class defaults
`define LPMN_ATTR_DEFAULT 2'h0
`define LPMN_TC_DEFAULT 3'h0
`endif

/* File: lpmn_pkg.sv */
// types of the link power-management entry negotiation block
package lpmn_pkg;
    // training machine state as seen by this block
    typedef enum logic [1:0] {
        LPMN_LT_L0 = 2'h0,
        LPMN_LT_RECOVERY = 2'h1,
        LPMN_LT_CONFIG = 2'h2,
        LPMN_LT_OTHER = 2'h3
    } lpmn_ltssm_type;
    // power-management dllp kinds
    typedef enum logic [2:0] {
        LPMN_DLLP_NONE = 3'h0,
        LPMN_DLLP_ENTER_L1 = 3'h1,
        LPMN_DLLP_ENTER_L23 = 3'h2,
        LPMN_DLLP_AS_REQ_L1 = 3'h3,
        LPMN_DLLP_REQ_ACK = 3'h4
    } lpmn_dllp_type;
    // power-management messages
    typedef enum logic [1:0] {
        LPMN_MSG_AS_NAK = 2'h0,
        LPMN_MSG_PME = 2'h1,
        LPMN_MSG_TURN_OFF = 2'h2,
        LPMN_MSG_TO_ACK = 2'h3
    } lpmn_msg_type;
    // kind of negotiation in progress
    typedef enum logic [1:0] {
        LPMN_KIND_SW_L1 = 2'h0,
        LPMN_KIND_ASPM_L1 = 2'h1,
        LPMN_KIND_L23 = 2'h2
    } lpmn_kind_type;
    // negotiation machine states
    typedef enum logic [2:0] {
        LPMN_ST_IDLE,
        LPMN_ST_NEGOTIATE,
        LPMN_ST_REJECT,
        LPMN_ST_LOWPWR,
        LPMN_ST_EXIT
    } lpmn_state_type;
endpackage : lpmn_pkg

/* File: lpmn_msg_fmt.sv */
// header field encoder for power-management messages
`timescale 1ns/1ps
`include "lpmn_regs.svh"
module lpmn_msg_fmt #(
    parameter bit NAK_RID_FUNC = 1'b1 // nak carries function number
) (
    input wire lpmn_pkg::lpmn_msg_type msg_in,
    output logic [7:0] code_out,
    output logic [2:0] route_out,
    output logic [1:0] attr_out,
    output logic [2:0] tc_out,
    output logic rid_func_out
);
    // field lookup per message
    always_comb
    begin
        attr_out = `LPMN_ATTR_DEFAULT;
        tc_out = `LPMN_TC_DEFAULT;
        rid_func_out = 1'b1;
        unique case (msg_in)
            lpmn_pkg::LPMN_MSG_AS_NAK:
            begin
                code_out = `LPMN_CODE_AS_NAK;
                route_out = `LPMN_ROUTE_AS_NAK;
                rid_func_out = NAK_RID_FUNC;
            end
            lpmn_pkg::LPMN_MSG_PME:
            begin
                code_out = `LPMN_CODE_PME;
                route_out = `LPMN_ROUTE_PME;
            end
            lpmn_pkg::LPMN_MSG_TURN_OFF:
            begin
                code_out = `LPMN_CODE_TURN_OFF;
                route_out = `LPMN_ROUTE_TURN_OFF;
            end
            lpmn_pkg::LPMN_MSG_TO_ACK:
            begin
                code_out = `LPMN_CODE_TO_ACK;
                route_out = `LPMN_ROUTE_TO_ACK;
                rid_func_out = 1'b1;
            end
        endcase
    end
endmodule : lpmn_msg_fmt

/* File: lpmn_top.sv */
// link power-management entry negotiation, one link end
`timescale 1ns/1ps
`include "lpmn_regs.svh"
module lpmn_top #(
    parameter bit DOWNSTREAM = 1'b1, // 1: downstream component
    parameter int NUM_DS_PORTS = 1, // switch downstream ports
    parameter bit NAK_RID_FUNC = 1'b1 // nak carries function number
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire lpmn_pkg::lpmn_ltssm_type ltssm_in,
    input wire logic link_up_in,
    input wire logic sw_l1_req_in,
    input wire logic aspm_l1_req_in,
    input wire logic l23_req_in,
    input wire logic can_accept_in,
    input wire logic rx_dllp_valid_in,
    input wire lpmn_pkg::lpmn_dllp_type rx_dllp_type_in,
    input wire logic rx_as_nak_in,
    input wire logic rx_idle_in,
    input wire logic tlp_pending_in,
    input wire logic pme_req_in,
    input wire logic [NUM_DS_PORTS-1:0] to_ack_rx_in,
    input wire logic msg_ready_in,
    output logic tx_dllp_valid_out,
    output lpmn_pkg::lpmn_dllp_type tx_dllp_type_out,
    output logic tlp_block_out,
    output logic low_power_out,
    output logic exit_req_out,
    output logic msg_valid_out,
    output lpmn_pkg::lpmn_msg_type msg_type_out,
    output logic [7:0] msg_code_out,
    output logic [2:0] msg_route_out,
    output logic [1:0] msg_attr_out,
    output logic [2:0] msg_tc_out,
    output logic msg_rid_func_out
);
    // power-management view of L0
    function automatic logic pm_in_l0(input lpmn_pkg::lpmn_ltssm_type lt,
                                      input logic up);
        pm_in_l0 = (lt == lpmn_pkg::LPMN_LT_L0) ||
                   (lt == lpmn_pkg::LPMN_LT_RECOVERY) ||
                   (lt == lpmn_pkg::LPMN_LT_CONFIG && up);
    endfunction : pm_in_l0

    lpmn_pkg::lpmn_state_type state_r, state_nxt; // negotiation state
    lpmn_pkg::lpmn_kind_type kind_r, kind_nxt; // negotiation kind
    lpmn_pkg::lpmn_dllp_type dllp_r, dllp_nxt; // dllp being repeated
    logic restart_r, restart_nxt; // downstream must renegotiate
    logic interrupt; // link went through recovery or down
    logic nak_set; // upstream rejected a request

    assign interrupt = (ltssm_in == lpmn_pkg::LPMN_LT_RECOVERY) ||
                       !link_up_in;

    // negotiation next state
    always_comb
    begin
        state_nxt = state_r;
        kind_nxt = kind_r;
        dllp_nxt = dllp_r;
        restart_nxt = restart_r;
        nak_set = 1'b0;
        unique case (state_r)
            lpmn_pkg::LPMN_ST_IDLE:
            begin
                if (!link_up_in)
                begin
                    restart_nxt = 1'b0; // link down drops a pending restart
                end
                else if (ltssm_in != lpmn_pkg::LPMN_LT_L0)
                begin
                    state_nxt = lpmn_pkg::LPMN_ST_IDLE; // wait for L0
                end
                else if (DOWNSTREAM && restart_r)
                begin
                    state_nxt = lpmn_pkg::LPMN_ST_NEGOTIATE;
                    restart_nxt = 1'b0;
                end
                else if (DOWNSTREAM &&
                         (l23_req_in || sw_l1_req_in || aspm_l1_req_in))
                begin
                    state_nxt = lpmn_pkg::LPMN_ST_NEGOTIATE;
                    if (l23_req_in)
                    begin
                        kind_nxt = lpmn_pkg::LPMN_KIND_L23;
                        dllp_nxt = lpmn_pkg::LPMN_DLLP_ENTER_L23;
                    end
                    else if (sw_l1_req_in)
                    begin
                        kind_nxt = lpmn_pkg::LPMN_KIND_SW_L1;
                        dllp_nxt = lpmn_pkg::LPMN_DLLP_ENTER_L1;
                    end
                    else
                    begin
                        kind_nxt = lpmn_pkg::LPMN_KIND_ASPM_L1;
                        dllp_nxt = lpmn_pkg::LPMN_DLLP_AS_REQ_L1;
                    end
                end
                else if (!DOWNSTREAM && rx_dllp_valid_in)
                begin
                    dllp_nxt = lpmn_pkg::LPMN_DLLP_REQ_ACK;
                    if (rx_dllp_type_in == lpmn_pkg::LPMN_DLLP_ENTER_L1)
                    begin
                        state_nxt = lpmn_pkg::LPMN_ST_NEGOTIATE;
                        kind_nxt = lpmn_pkg::LPMN_KIND_SW_L1;
                    end
                    else if (rx_dllp_type_in ==
                             lpmn_pkg::LPMN_DLLP_ENTER_L23)
                    begin
                        state_nxt = lpmn_pkg::LPMN_ST_NEGOTIATE;
                        kind_nxt = lpmn_pkg::LPMN_KIND_L23;
                    end
                    else if (rx_dllp_type_in ==
                             lpmn_pkg::LPMN_DLLP_AS_REQ_L1)
                    begin
                        kind_nxt = lpmn_pkg::LPMN_KIND_ASPM_L1;
                        if (can_accept_in)
                        begin
                            state_nxt = lpmn_pkg::LPMN_ST_NEGOTIATE;
                        end
                        else
                        begin
                            state_nxt = lpmn_pkg::LPMN_ST_REJECT;
                            nak_set = 1'b1;
                        end
                    end
                end
            end
            lpmn_pkg::LPMN_ST_NEGOTIATE:
            begin
                if (interrupt || !pm_in_l0(ltssm_in, link_up_in))
                begin
                    state_nxt = lpmn_pkg::LPMN_ST_IDLE;
                    restart_nxt = DOWNSTREAM && link_up_in;
                end
                else if (DOWNSTREAM && rx_dllp_valid_in &&
                         rx_dllp_type_in == lpmn_pkg::LPMN_DLLP_REQ_ACK)
                begin
                    state_nxt = lpmn_pkg::LPMN_ST_LOWPWR;
                end
                else if (DOWNSTREAM && rx_as_nak_in &&
                         kind_r == lpmn_pkg::LPMN_KIND_ASPM_L1)
                begin
                    state_nxt = lpmn_pkg::LPMN_ST_IDLE; // rejected
                end
                else if (!DOWNSTREAM && rx_idle_in)
                begin
                    state_nxt = lpmn_pkg::LPMN_ST_LOWPWR;
                end
            end
            lpmn_pkg::LPMN_ST_REJECT:
            begin
                state_nxt = lpmn_pkg::LPMN_ST_IDLE; // nak queued
            end
            lpmn_pkg::LPMN_ST_LOWPWR:
            begin
                if (!link_up_in)
                begin
                    state_nxt = lpmn_pkg::LPMN_ST_IDLE; // link down
                end
                else if (kind_r != lpmn_pkg::LPMN_KIND_L23 &&
                         ((tlp_pending_in && rx_idle_in) ||
                          ltssm_in == lpmn_pkg::LPMN_LT_RECOVERY))
                begin
                    state_nxt = lpmn_pkg::LPMN_ST_EXIT;
                end
            end
            lpmn_pkg::LPMN_ST_EXIT:
            begin
                if (!link_up_in ||
                    (ltssm_in == lpmn_pkg::LPMN_LT_L0 && !rx_idle_in))
                begin
                    state_nxt = lpmn_pkg::LPMN_ST_IDLE; // back in L0
                end
            end
            default:
            begin
                state_nxt = lpmn_pkg::LPMN_ST_IDLE;
            end
        endcase
    end

    // negotiation registers
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            state_r <= lpmn_pkg::LPMN_ST_IDLE;
            kind_r <= lpmn_pkg::LPMN_KIND_SW_L1;
            dllp_r <= lpmn_pkg::LPMN_DLLP_NONE;
            restart_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            kind_r <= kind_nxt;
            dllp_r <= dllp_nxt;
            restart_r <= restart_nxt;
        end
    end

    // dllp repeated every cycle while negotiating
    assign tx_dllp_valid_out = (state_r == lpmn_pkg::LPMN_ST_NEGOTIATE);
    assign tx_dllp_type_out = dllp_r;
    // tlps held from entry start until link back in L0
    assign tlp_block_out = (state_r == lpmn_pkg::LPMN_ST_NEGOTIATE) ||
                           (state_r == lpmn_pkg::LPMN_ST_LOWPWR) ||
                           (state_r == lpmn_pkg::LPMN_ST_EXIT);
    assign low_power_out = (state_r == lpmn_pkg::LPMN_ST_LOWPWR);
    assign exit_req_out = (state_r == lpmn_pkg::LPMN_ST_EXIT);

    logic pme_pend_r, pme_pend_nxt; // pme message waiting
    logic ack_pend_r, ack_pend_nxt; // turn-off ack waiting
    logic nak_pend_r, nak_pend_nxt; // aspm nak waiting
    logic [NUM_DS_PORTS-1:0] seen_r, seen_nxt; // acks from ports
    logic msg_valid_r, msg_valid_nxt; // message offered
    lpmn_pkg::lpmn_msg_type msg_r, msg_nxt; // message selected
    lpmn_pkg::lpmn_msg_type sel; // message about to load
    logic load; // load a new message
    logic [7:0] code_r, code_w; // message code
    logic [2:0] route_r, route_w; // routing subfield
    logic [1:0] attr_r, attr_w; // attribute field
    logic [2:0] tc_r, tc_w; // traffic class
    logic rid_r, rid_w; // requester id has function

    // field encoder for the selected message
    lpmn_msg_fmt #(
        .NAK_RID_FUNC(NAK_RID_FUNC)
    ) u_fmt (
        .msg_in(sel),
        .code_out(code_w),
        .route_out(route_w),
        .attr_out(attr_w),
        .tc_out(tc_w),
        .rid_func_out(rid_w)
    );

    // message pending flags and selection, set wins over clear
    always_comb
    begin
        seen_nxt = seen_r | to_ack_rx_in;
        msg_valid_nxt = msg_valid_r && !msg_ready_in;
        msg_nxt = msg_r;
        load = 1'b0;
        if (nak_pend_r)
        begin
            sel = lpmn_pkg::LPMN_MSG_AS_NAK; // rejection first
        end
        else if (ack_pend_r)
        begin
            sel = lpmn_pkg::LPMN_MSG_TO_ACK;
        end
        else
        begin
            sel = lpmn_pkg::LPMN_MSG_PME;
        end
        if (!msg_valid_r && (nak_pend_r || ack_pend_r || pme_pend_r))
        begin
            load = 1'b1;
            msg_valid_nxt = 1'b1;
            msg_nxt = sel;
        end
        nak_pend_nxt = (nak_pend_r &&
                        !(load && sel == lpmn_pkg::LPMN_MSG_AS_NAK)) ||
                       nak_set;
        pme_pend_nxt = (pme_pend_r &&
                        !(load && sel == lpmn_pkg::LPMN_MSG_PME)) ||
                       (DOWNSTREAM && pme_req_in);
        ack_pend_nxt = ack_pend_r &&
                       !(load && sel == lpmn_pkg::LPMN_MSG_TO_ACK);
        if (DOWNSTREAM && (&seen_nxt))
        begin
            ack_pend_nxt = 1'b1;
            seen_nxt = '0;
        end
    end

    // message registers
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            pme_pend_r <= 1'b0;
            ack_pend_r <= 1'b0;
            nak_pend_r <= 1'b0;
            seen_r <= '0;
            msg_valid_r <= 1'b0;
            msg_r <= lpmn_pkg::LPMN_MSG_PME;
            code_r <= 8'h00;
            route_r <= 3'h0;
            attr_r <= 2'h0;
            tc_r <= 3'h0;
            rid_r <= 1'b0;
        end
        else
        begin
            pme_pend_r <= pme_pend_nxt;
            ack_pend_r <= ack_pend_nxt;
            nak_pend_r <= nak_pend_nxt;
            seen_r <= seen_nxt;
            msg_valid_r <= msg_valid_nxt;
            msg_r <= msg_nxt;
            if (load)
            begin
                code_r <= code_w;
                route_r <= route_w;
                attr_r <= attr_w;
                tc_r <= tc_w;
                rid_r <= rid_w;
            end
        end
    end

    assign msg_valid_out = msg_valid_r;
    assign msg_type_out = msg_r;
    assign msg_code_out = code_r;
    assign msg_route_out = route_r;
    assign msg_attr_out = attr_r;
    assign msg_tc_out = tc_r;
    assign msg_rid_func_out = rid_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // negotiation start from idle
    sequence s_start;
        state_r == lpmn_pkg::LPMN_ST_IDLE ##1
        state_r == lpmn_pkg::LPMN_ST_NEGOTIATE;
    endsequence
    // downstream interruption during negotiation
    sequence s_ds_break;
        DOWNSTREAM && state_r == lpmn_pkg::LPMN_ST_NEGOTIATE && interrupt &&
        link_up_in;
    endsequence

    a_reset_to_idle: assert property (disable iff (1'b0)
        !rst_n_in |=> state_r == lpmn_pkg::LPMN_ST_IDLE)
        else $error("machine not idle after reset");
    a_first_send_dllp: assert property (s_start |->
        tx_dllp_valid_out && tx_dllp_type_out != lpmn_pkg::LPMN_DLLP_NONE)
        else $error("no entry dllp on leaving idle");
    a_break_to_idle: assert property (
        state_r == lpmn_pkg::LPMN_ST_NEGOTIATE && interrupt
        |=> state_r == lpmn_pkg::LPMN_ST_IDLE)
        else $error("interrupted negotiation not idle");
    a_up_waits_dllp: assert property (!DOWNSTREAM &&
        state_r == lpmn_pkg::LPMN_ST_IDLE && !rx_dllp_valid_in
        |=> state_r == lpmn_pkg::LPMN_ST_IDLE)
        else $error("upstream left idle without dllp");
    a_ds_restart: assert property (s_ds_break ##1
        (ltssm_in == lpmn_pkg::LPMN_LT_L0 && link_up_in)
        |=> state_r == lpmn_pkg::LPMN_ST_NEGOTIATE &&
            dllp_r == $past(dllp_r, 2))
        else $error("downstream did not restart");
    a_low_after_neg: assert property (
        $rose(low_power_out) |-> $past(state_r) == lpmn_pkg::LPMN_ST_NEGOTIATE)
        else $error("low state without negotiation");
    a_l23_repeats: assert property (DOWNSTREAM &&
        state_r == lpmn_pkg::LPMN_ST_NEGOTIATE &&
        kind_r == lpmn_pkg::LPMN_KIND_L23 && !interrupt && !rx_dllp_valid_in
        |=> tx_dllp_valid_out &&
            tx_dllp_type_out == lpmn_pkg::LPMN_DLLP_ENTER_L23)
        else $error("l23 entry dllp not repeated");
    a_aspm_reject: assert property (!DOWNSTREAM &&
        state_r == lpmn_pkg::LPMN_ST_IDLE && link_up_in &&
        ltssm_in == lpmn_pkg::LPMN_LT_L0 && rx_dllp_valid_in &&
        rx_dllp_type_in == lpmn_pkg::LPMN_DLLP_AS_REQ_L1 && !can_accept_in
        |=> state_r == lpmn_pkg::LPMN_ST_REJECT ##1 nak_pend_r || msg_valid_r)
        else $error("aspm request not rejected at once");
    a_tlp_held: assert property (
        state_r == lpmn_pkg::LPMN_ST_NEGOTIATE && tlp_pending_in
        |-> tlp_block_out && !exit_req_out)
        else $error("tlp released during negotiation");
    a_msg_defaults: assert property (
        msg_valid_out |-> msg_attr_out == 2'h0 && msg_tc_out == 3'h0)
        else $error("message attr or tc not zero");
    a_pme_code: assert property (
        msg_valid_out && msg_type_out == lpmn_pkg::LPMN_MSG_PME
        |-> msg_code_out == 8'h18 && msg_route_out == 3'h0)
        else $error("pme message fields wrong");
endmodule : lpmn_top

/* File: lpmn_far_model.sv */
// far-end model: upstream power-management logic facing the block
`timescale 1ns/1ps
module lpmn_far_model (
    input wire logic clk_in,
    input wire logic link_up_in,
    input wire logic tx_valid_in,
    input wire lpmn_pkg::lpmn_dllp_type tx_type_in,
    input wire logic exit_req_in,
    input wire logic [1:0] mode_in, // 0 accept, 1 reject, 2 stall
    input wire logic [3:0] delay_in, // cycles before answering
    output logic rx_valid_out,
    output lpmn_pkg::lpmn_dllp_type rx_type_out,
    output logic rx_nak_out,
    output logic rx_idle_out
);
    logic [3:0] wait_r; // cycles the request has been seen
    // quiet outputs at time zero
    initial
    begin
        wait_r = 4'h0;
        rx_valid_out = 1'b0;
        rx_type_out = lpmn_pkg::LPMN_DLLP_NONE;
        rx_nak_out = 1'b0;
        rx_idle_out = 1'b0;
    end
    // answers on the falling edge, dllp and nak as one-cycle pulses, idle held as a level
    always @(negedge clk_in)
    begin
        rx_valid_out <= 1'b0;
        rx_nak_out <= 1'b0;
        rx_type_out <= lpmn_pkg::LPMN_DLLP_NONE;
        if (exit_req_in || !link_up_in)
        begin
            rx_idle_out <= 1'b0; // wake or link loss leaves idle
        end
        if (tx_valid_in !== 1'b1)
        begin
            wait_r <= 4'h0;
        end
        else if (wait_r < delay_in)
        begin
            wait_r <= wait_r + 4'h1; // slow answer
        end
        else if (mode_in == 2'h0)
        begin
            rx_valid_out <= 1'b1;
            rx_type_out <= lpmn_pkg::LPMN_DLLP_REQ_ACK;
            rx_idle_out <= 1'b1; // both ends settle into idle
            wait_r <= 4'h0;
        end
        else if (mode_in == 2'h1 &&
            tx_type_in == lpmn_pkg::LPMN_DLLP_AS_REQ_L1)
        begin
            rx_nak_out <= 1'b1;
            wait_r <= 4'h0;
        end
    end
endmodule : lpmn_far_model

/* File: tb.sv */
// self-checking bench for the negotiation block, downstream end and upstream end
`timescale 1ns/1ps
module tb;
    logic clk_in = 1'b0;
    logic rst_n = 1'b0;
    lpmn_pkg::lpmn_ltssm_type ltssm = lpmn_pkg::LPMN_LT_L0;
    logic link_up = 1'b1, sw = 1'b0, aspm = 1'b0, l23 = 1'b0;
    logic tlp_pend = 1'b0, pme_req = 1'b0, msg_ready = 1'b0;
    logic [1:0] to_ack = 2'h0, mode = 2'h0;
    logic [3:0] delay = 4'h0;
    logic rx_valid, rx_nak, rx_idle, tx_valid, blk, low, exit_req;
    logic msg_valid, rid_func;
    lpmn_pkg::lpmn_dllp_type rx_type, tx_type;
    lpmn_pkg::lpmn_msg_type msg_type;
    logic [7:0] code;
    logic [2:0] route, tc;
    logic [1:0] attr;
    logic up_acc = 1'b0, u_rv = 1'b0, u_tv, u_blk, u_mv, u_rid;
    lpmn_pkg::lpmn_dllp_type u_rt = lpmn_pkg::LPMN_DLLP_NONE, u_tt;
    logic [7:0] u_code;
    logic [2:0] u_route;
    int miscompares = 0;
    int tests_run = 0;
    // 8 ns clock
    always #4 clk_in = ~clk_in;
    lpmn_top #(.DOWNSTREAM(1'b1), .NUM_DS_PORTS(2), .NAK_RID_FUNC(1'b0)) DUT (
        .clk_in(clk_in), .rst_n_in(rst_n), .ltssm_in(ltssm),
        .link_up_in(link_up), .sw_l1_req_in(sw), .aspm_l1_req_in(aspm),
        .l23_req_in(l23), .can_accept_in(1'b1),
        .rx_dllp_valid_in(rx_valid), .rx_dllp_type_in(rx_type),
        .rx_as_nak_in(rx_nak), .rx_idle_in(rx_idle),
        .tlp_pending_in(tlp_pend), .pme_req_in(pme_req),
        .to_ack_rx_in(to_ack), .msg_ready_in(msg_ready),
        .tx_dllp_valid_out(tx_valid), .tx_dllp_type_out(tx_type),
        .tlp_block_out(blk), .low_power_out(low), .exit_req_out(exit_req),
        .msg_valid_out(msg_valid), .msg_type_out(msg_type),
        .msg_code_out(code), .msg_route_out(route), .msg_attr_out(attr),
        .msg_tc_out(tc), .msg_rid_func_out(rid_func));
    lpmn_far_model far (
        .clk_in(clk_in), .link_up_in(link_up), .tx_valid_in(tx_valid),
        .tx_type_in(tx_type), .exit_req_in(exit_req), .mode_in(mode),
        .delay_in(delay), .rx_valid_out(rx_valid), .rx_type_out(rx_type),
        .rx_nak_out(rx_nak), .rx_idle_out(rx_idle));
    // upstream end, fed straight from the bench
    lpmn_top #(.DOWNSTREAM(1'b0), .NAK_RID_FUNC(1'b0)) DUT_UP (
        .clk_in(clk_in), .rst_n_in(rst_n), .ltssm_in(ltssm),
        .link_up_in(link_up), .sw_l1_req_in(1'b0), .aspm_l1_req_in(1'b0),
        .l23_req_in(1'b0), .can_accept_in(up_acc),
        .rx_dllp_valid_in(u_rv), .rx_dllp_type_in(u_rt),
        .rx_as_nak_in(1'b0), .rx_idle_in(1'b0), .tlp_pending_in(1'b0),
        .pme_req_in(1'b0), .to_ack_rx_in(1'b0), .msg_ready_in(msg_ready),
        .tx_dllp_valid_out(u_tv), .tx_dllp_type_out(u_tt),
        .tlp_block_out(u_blk), .low_power_out(), .exit_req_out(),
        .msg_valid_out(u_mv), .msg_type_out(), .msg_code_out(u_code),
        .msg_route_out(u_route), .msg_attr_out(), .msg_tc_out(),
        .msg_rid_func_out(u_rid));
    // step to the next falling edge, where inputs change
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cyc
    // compare and count
    task automatic chk(input string nm, input logic [7:0] seen,
        input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // bounded wait for a level
    task automatic wait_for(ref logic s, input logic v);
        for (int i = 0; i < 40 && s !== v; i++) cyc(1);
    endtask : wait_for
    // verdict and end of run
    task automatic finish_test();
        if (miscompares == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    // wake from the low state with a pending tlp
    task automatic do_exit();
        tlp_pend = 1'b1;
        wait_for(exit_req, 1'b1);
        chk("exit_req", exit_req, 1'b1);
        tlp_pend = 1'b0;
        wait_for(exit_req, 1'b0);
        chk("tlp_block", blk, 1'b0);
    endtask : do_exit
    // software L1 with a tlp arriving mid-negotiation
    task automatic t_sw_l1();
        mode = 2'h0;
        delay = 4'h5;
        sw = 1'b1;
        cyc(1);
        chk("tx_valid", tx_valid, 1'b1);
        chk("tx_type", tx_type, lpmn_pkg::LPMN_DLLP_ENTER_L1);
        chk("tlp_block", blk, 1'b1);
        sw = 1'b0;
        tlp_pend = 1'b1;
        cyc(2);
        chk("low", low, 1'b0);
        chk("exit_req", exit_req, 1'b0);
        wait_for(low, 1'b1);
        chk("low", low, 1'b1);
        chk("tx_valid", tx_valid, 1'b0);
        do_exit();
    endtask : t_sw_l1
    // aspm request refused by the far end
    task automatic t_aspm_rej();
        mode = 2'h1;
        delay = 4'h0;
        aspm = 1'b1;
        cyc(1);
        chk("tx_type", tx_type, lpmn_pkg::LPMN_DLLP_AS_REQ_L1);
        aspm = 1'b0;
        cyc(3);
        chk("tx_valid", tx_valid, 1'b0);
        chk("low", low, 1'b0);
    endtask : t_aspm_rej
    // L2/L3 entry repeated while the far end stalls
    task automatic t_l23();
        mode = 2'h2;
        l23 = 1'b1;
        cyc(1);
        l23 = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            chk("tx_valid", tx_valid, 1'b1);
            chk("tx_type", tx_type, lpmn_pkg::LPMN_DLLP_ENTER_L23);
            cyc(1);
        end
        mode = 2'h0;
        wait_for(low, 1'b1);
        chk("low", low, 1'b1);
        link_up = 1'b0;
        cyc(2);
        chk("low", low, 1'b0);
        link_up = 1'b1;
        cyc(3);
        chk("tx_valid", tx_valid, 1'b0);
    endtask : t_l23
    // configuration holds, recovery interrupts and restarts
    task automatic t_interrupt();
        mode = 2'h2;
        sw = 1'b1;
        cyc(1);
        sw = 1'b0;
        ltssm = lpmn_pkg::LPMN_LT_CONFIG;
        cyc(3);
        chk("tx_valid", tx_valid, 1'b1);
        ltssm = lpmn_pkg::LPMN_LT_RECOVERY;
        cyc(1);
        chk("tx_valid", tx_valid, 1'b0);
        ltssm = lpmn_pkg::LPMN_LT_L0;
        wait_for(tx_valid, 1'b1);
        chk("tx_valid", tx_valid, 1'b1);
        chk("tx_type", tx_type, lpmn_pkg::LPMN_DLLP_ENTER_L1);
        mode = 2'h0;
        wait_for(low, 1'b1);
        do_exit();
    endtask : t_interrupt
    // take one offered message and check its header fields
    task automatic take_msg(input logic [7:0] c, input logic [2:0] r,
        input lpmn_pkg::lpmn_msg_type t);
        wait_for(msg_valid, 1'b1);
        chk("msg_type", msg_type, t);
        chk("msg_code", code, c);
        chk("msg_route", {5'h00, route}, {5'h00, r});
        chk("msg_attr", {6'h00, attr}, 8'h00);
        chk("msg_tc", {5'h00, tc}, 8'h00);
        chk("msg_rid_func", rid_func, 1'b1);
        msg_ready = 1'b1;
        cyc(1);
        msg_ready = 1'b0;
        cyc(1);
        chk("msg_valid", msg_valid, 1'b0);
    endtask : take_msg
    // event message, then turn-off ack gathered from both ports
    task automatic t_msgs();
        pme_req = 1'b1;
        cyc(1);
        pme_req = 1'b0;
        take_msg(8'h18, 3'h0, lpmn_pkg::LPMN_MSG_PME);
        to_ack = 2'h1;
        cyc(1);
        to_ack = 2'h0;
        cyc(3);
        chk("msg_valid", msg_valid, 1'b0);
        to_ack = 2'h2;
        cyc(1);
        to_ack = 2'h0;
        take_msg(8'h1B, 3'h5, lpmn_pkg::LPMN_MSG_TO_ACK);
    endtask : t_msgs
    // upstream end: refuse, then accept and lose an aspm request
    task automatic t_up();
        u_rt = lpmn_pkg::LPMN_DLLP_AS_REQ_L1;
        u_rv = 1'b1;
        cyc(1);
        u_rv = 1'b0;
        cyc(1);
        chk("up_tx_valid", u_tv, 1'b0);
        chk("up_msg_valid", u_mv, 1'b1);
        chk("up_msg_code", u_code, 8'h14);
        chk("up_msg_route", {5'h00, u_route}, 8'h04);
        chk("up_msg_rid_func", u_rid, 1'b0);
        msg_ready = 1'b1;
        cyc(1);
        msg_ready = 1'b0;
        up_acc = 1'b1;
        u_rv = 1'b1;
        cyc(1);
        u_rv = 1'b0;
        chk("up_tx_valid", u_tv, 1'b1);
        chk("up_tx_type", u_tt, lpmn_pkg::LPMN_DLLP_REQ_ACK);
        chk("up_tlp_block", u_blk, 1'b1);
        ltssm = lpmn_pkg::LPMN_LT_RECOVERY;
        cyc(1);
        chk("up_tx_valid", u_tv, 1'b0);
        ltssm = lpmn_pkg::LPMN_LT_L0;
        cyc(2);
        chk("up_tx_valid", u_tv, 1'b0);
    endtask : t_up
    // main sequence
    initial
    begin
        cyc(3);
        chk("tx_valid", tx_valid, 1'b0);
        chk("low", low, 1'b0);
        chk("msg_valid", msg_valid, 1'b0);
        rst_n = 1'b1;
        cyc(1);
        t_sw_l1();
        t_aspm_rej();
        t_l23();
        t_interrupt();
        t_msgs();
        t_up();
        finish_test();
    end
    // hang guard, far beyond the few dozen cycles used
    initial
    begin
        #100000;
        miscompares++;
        finish_test();
    end
endmodule : tb
